/* File: limit_readback_pkg.sv */
package limit_readback_pkg;

    // ========================================================================
    // Command codes
    localparam logic [7:0] CMD_OVER_VOLTAGE_PROTECTION_LIMIT     = 8'h40;
    localparam logic [7:0] CMD_OVER_VOLTAGE_PROTECTION_RESPONSE  = 8'h41;
    localparam logic [7:0] CMD_UNDER_VOLTAGE_PROTECTION_LIMIT    = 8'h44;
    localparam logic [7:0] CMD_UNDER_VOLTAGE_PROTECTION_RESPONSE = 8'h45;
    localparam logic [7:0] CMD_OTP_LIMIT                         = 8'h4F;
    localparam logic [7:0] CMD_OTP_RESPONSE                      = 8'h50;
    localparam logic [7:0] CMD_OVER_POWER_PROTECTION_LIMIT       = 8'h68;

    // ========================================================================
    // Reply encodings
    localparam logic [15:0] DISABLED_VALUE  = 16'h00FF;
    localparam logic [1:0]  REACT_LATCH     = 2'h2;
    localparam logic [1:0]  REACT_RESTART   = 2'h3;
    localparam int          REACT_POS       = 6;
    localparam logic [5:0]  REACT_UNDEF     = 6'h00;

    // ========================================================================
    // Bus framing
    localparam logic [6:0] DEFAULT_ADDR     = 7'h10;
    localparam logic       DIR_WRITE        = 1'h0;
    localparam logic       DIR_READ         = 1'h1;

    // ========================================================================
    // Packet error code
    localparam logic [7:0] CRC_POLY         = 8'h07;
    localparam logic [7:0] CRC_INIT         = 8'h00;

    // ========================================================================
    // Reset values
    localparam logic [1:0] IDX_RESET        = 2'h0;
    localparam logic [7:0] BYTE_RESET       = 8'h00;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_WADDR  = 6'b000010,
        ST_CMD    = 6'b000100,
        ST_WAIT   = 6'b001000,
        ST_RADDR  = 6'b010000,
        ST_SEND   = 6'b100000
    } resp_state_e;

endpackage

/* File: crc_if.sv */
`timescale 1ns/1ps

interface crc_if;
    logic       clear;
    logic       update;
    logic [7:0] data;
    logic [7:0] crc;

    modport engine (
        input  clear,
        input  update,
        input  data,
        output crc
    );

    modport user (
        output clear,
        output update,
        output data,
        input  crc
    );
endinterface

/* File: pec_crc8.sv */
`timescale 1ns/1ps

module pec_crc8 (
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    crc_if.engine     crc
);

    logic [7:0] crc_q;

    // ========================================================================
    // Bytewise CRC-8, MSB first
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ limit_readback_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            crc_q <= limit_readback_pkg::CRC_INIT;
        end else if (crc.clear && crc.update) begin
            crc_q <= crc_step(limit_readback_pkg::CRC_INIT, crc.data);
        end else if (crc.clear) begin
            crc_q <= limit_readback_pkg::CRC_INIT;
        end else if (crc.update) begin
            crc_q <= crc_step(crc_q, crc.data);
        end
    end

    assign crc.crc = crc_q;

endmodule

/* File: protection_limit_readback.sv */
`timescale 1ns/1ps

// Contract
// - Command 0x40 returns over-voltage threshold, two bytes, then PEC.
// - Command 0x41 returns over-voltage fault reaction byte, then PEC.
// - Command 0x44 returns under-voltage threshold, two bytes, then PEC.
// - Command 0x45 returns under-voltage fault reaction byte, then PEC.
// - Command 0x4F returns over-temperature threshold, two bytes, PEC.
// - Command 0x50 returns over-temperature reaction byte, then PEC.
// - Command 0x68 returns over-power threshold, two bytes, then PEC.
// - A disabled protection reports its threshold as 0xFF.
// - Reaction bits 7:6: 10 latch-off, 11 auto-restart; rest undefined.
// - Two-byte values are ten times the quantity, one implied decimal.
// - Two-byte values go low byte first, high byte second.
module protection_limit_readback #(
    parameter logic [6:0] SLAVE_ADDR = limit_readback_pkg::DEFAULT_ADDR
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_start,
    input  wire logic        i_stop,
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_byte,
    input  wire logic        i_tx_req,
    input  wire logic        i_tx_nack,
    input  wire logic [15:0] i_over_voltage_protection_limit,
    input  wire logic        i_over_voltage_protection_enable,
    input  wire logic        i_over_voltage_protection_restart,
    input  wire logic [15:0] i_under_voltage_protection_limit,
    input  wire logic        i_under_voltage_protection_enable,
    input  wire logic        i_under_voltage_protection_restart,
    input  wire logic [15:0] i_otp_limit,
    input  wire logic        i_otp_enable,
    input  wire logic        i_otp_restart,
    input  wire logic [15:0] i_over_power_protection_limit,
    input  wire logic        i_over_power_protection_enable,
    output logic             o_rx_ack,
    output logic [7:0]       o_tx_byte,
    output logic             o_tx_valid,
    output logic             o_busy
);

    limit_readback_pkg::resp_state_e state_q;
    logic [15:0] reply_q;
    logic        two_byte_q;
    logic [1:0]  idx_q;
    logic [1:0]  last_idx;
    logic        cmd_known;
    logic        is_two;
    logic [15:0] reply_d;
    logic        addr_w_ok;
    logic        addr_r_ok;
    logic [7:0]  next_byte;

    crc_if pec ();

    pec_crc8 u_pec (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .crc    (pec)
    );

    // ========================================================================
    // Reply encoding helpers
    function automatic logic [15:0] limit_word(input logic [15:0] v,
                                               input logic        en);
        return en ? v : limit_readback_pkg::DISABLED_VALUE;
    endfunction

    function automatic logic [15:0] react_word(input logic rs);
        logic [7:0] b;
        b = {(rs ? limit_readback_pkg::REACT_RESTART
                 : limit_readback_pkg::REACT_LATCH),
             limit_readback_pkg::REACT_UNDEF};
        return {8'h00, b};
    endfunction

    // ========================================================================
    // Command decode
    always_comb begin
        cmd_known = 1'b1;
        is_two    = 1'b1;
        reply_d   = 16'h0000;
        case (i_rx_byte)
            limit_readback_pkg::CMD_OVER_VOLTAGE_PROTECTION_LIMIT: begin
                reply_d = limit_word(
                    i_over_voltage_protection_limit,
                    i_over_voltage_protection_enable);
            end
            limit_readback_pkg::CMD_OVER_VOLTAGE_PROTECTION_RESPONSE: begin
                is_two  = 1'b0;
                reply_d = react_word(
                    i_over_voltage_protection_restart);
            end
            limit_readback_pkg::CMD_UNDER_VOLTAGE_PROTECTION_LIMIT: begin
                reply_d = limit_word(
                    i_under_voltage_protection_limit,
                    i_under_voltage_protection_enable);
            end
            limit_readback_pkg::CMD_UNDER_VOLTAGE_PROTECTION_RESPONSE: begin
                is_two  = 1'b0;
                reply_d = react_word(
                    i_under_voltage_protection_restart);
            end
            limit_readback_pkg::CMD_OTP_LIMIT: begin
                reply_d = limit_word(i_otp_limit, i_otp_enable);
            end
            limit_readback_pkg::CMD_OTP_RESPONSE: begin
                is_two  = 1'b0;
                reply_d = react_word(i_otp_restart);
            end
            limit_readback_pkg::CMD_OVER_POWER_PROTECTION_LIMIT: begin
                reply_d = limit_word(
                    i_over_power_protection_limit,
                    i_over_power_protection_enable);
            end
            default: begin
                cmd_known = 1'b0;
                is_two    = 1'b0;
            end
        endcase
    end

    // ========================================================================
    // Address match and acknowledge
    assign addr_w_ok = (i_rx_byte
                        == {SLAVE_ADDR, limit_readback_pkg::DIR_WRITE});
    assign addr_r_ok = (i_rx_byte
                        == {SLAVE_ADDR, limit_readback_pkg::DIR_READ});

    always_comb begin
        o_rx_ack = 1'b0;
        if (i_rx_valid) begin
            case (state_q)
                limit_readback_pkg::ST_WADDR: o_rx_ack = addr_w_ok;
                limit_readback_pkg::ST_CMD:   o_rx_ack = cmd_known;
                limit_readback_pkg::ST_RADDR: o_rx_ack = addr_r_ok;
                default:                      o_rx_ack = 1'b0;
            endcase
        end
    end

    // ========================================================================
    // Transaction sequencing
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || i_stop) begin
            state_q <= limit_readback_pkg::ST_IDLE;
        end else if (i_start) begin
            state_q <= (state_q == limit_readback_pkg::ST_WAIT)
                     ? limit_readback_pkg::ST_RADDR
                     : limit_readback_pkg::ST_WADDR;
        end else begin
            case (state_q)
                limit_readback_pkg::ST_WADDR: begin
                    if (i_rx_valid) begin
                        state_q <= addr_w_ok ? limit_readback_pkg::ST_CMD
                                             : limit_readback_pkg::ST_IDLE;
                    end
                end
                limit_readback_pkg::ST_CMD: begin
                    if (i_rx_valid) begin
                        state_q <= cmd_known ? limit_readback_pkg::ST_WAIT
                                             : limit_readback_pkg::ST_IDLE;
                    end
                end
                limit_readback_pkg::ST_WAIT: begin
                    if (i_rx_valid) begin
                        state_q <= limit_readback_pkg::ST_IDLE;
                    end
                end
                limit_readback_pkg::ST_RADDR: begin
                    if (i_rx_valid) begin
                        state_q <= addr_r_ok ? limit_readback_pkg::ST_SEND
                                             : limit_readback_pkg::ST_IDLE;
                    end
                end
                limit_readback_pkg::ST_SEND: begin
                    if (i_tx_nack || i_rx_valid) begin
                        state_q <= limit_readback_pkg::ST_IDLE;
                    end
                end
                default: state_q <= limit_readback_pkg::ST_IDLE;
            endcase
        end
    end

    // ========================================================================
    // Reply capture
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            reply_q    <= 16'h0000;
            two_byte_q <= 1'b0;
        end else if (state_q == limit_readback_pkg::ST_CMD && i_rx_valid
                     && cmd_known) begin
            reply_q    <= reply_d;
            two_byte_q <= is_two;
        end
    end

    // ========================================================================
    // Byte output
    assign last_idx  = two_byte_q ? 2'h2 : 2'h1;
    assign next_byte = (idx_q == last_idx) ? pec.crc
                     : (idx_q == 2'h0) ? reply_q[7:0]
                     : reply_q[15:8];

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            idx_q      <= limit_readback_pkg::IDX_RESET;
            o_tx_byte  <= limit_readback_pkg::BYTE_RESET;
            o_tx_valid <= 1'b0;
        end else begin
            o_tx_valid <= 1'b0;
            if (state_q != limit_readback_pkg::ST_SEND) begin
                idx_q <= limit_readback_pkg::IDX_RESET;
            end else if (i_tx_req && idx_q <= last_idx) begin
                o_tx_byte  <= next_byte;
                o_tx_valid <= 1'b1;
                idx_q      <= idx_q + 2'h1;
            end
        end
    end

    // ========================================================================
    // PEC accumulation over address, command and data bytes
    always_comb begin
        pec.clear  = (state_q == limit_readback_pkg::ST_WADDR) && i_rx_valid;
        pec.update = 1'b0;
        pec.data   = i_rx_byte;
        if (i_rx_valid && o_rx_ack) begin
            pec.update = 1'b1;
        end else if (state_q == limit_readback_pkg::ST_SEND && i_tx_req
                     && idx_q < last_idx) begin
            pec.update = 1'b1;
            pec.data   = next_byte;
        end
    end

    assign o_busy = (state_q != limit_readback_pkg::ST_IDLE);

endmodule

/* File: protection_limit_readback_sva.sv */
`timescale 1ns/1ps

// ==========================================================
// Checker on the responder ports
module protection_limit_readback_sva #(
    parameter logic [6:0] SLAVE_ADDR = 7'h10
) (
    input wire logic       i_mclk,
    input wire logic       i_rstn,
    input wire logic       i_start,
    input wire logic       i_stop,
    input wire logic       i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic       i_tx_req,
    input wire logic       i_tx_nack,
    input wire logic       o_rx_ack,
    input wire logic [7:0] o_tx_byte,
    input wire logic       o_tx_valid,
    input wire logic       o_busy
);
    logic       armed_q;
    logic       want_q;
    logic [1:0] ntx_q;
    logic       known;

    assign known = i_rx_byte inside {8'h40, 8'h41, 8'h44, 8'h45, 8'h4F,
                                     8'h50, 8'h68};
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) armed_q <= 1'b0;
        else if (i_start) armed_q <= !o_busy;
        else if (i_stop || i_rx_valid) armed_q <= 1'b0;
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || i_start || i_stop) want_q <= 1'b0;
        else if (i_rx_valid) want_q <= armed_q && o_rx_ack;
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !o_busy) ntx_q <= 2'h0;
        else if (o_tx_valid) ntx_q <= ntx_q + 2'h1;
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    AST_ADDR_ACK: assert property (
        armed_q && i_rx_valid && !i_start && !i_stop
        && i_rx_byte == {SLAVE_ADDR, 1'h0} |-> o_rx_ack)
        else $error("own write address not acknowledged");
    AST_ADDR_NACK: assert property (
        i_rx_valid && (armed_q || !o_busy) && i_rx_byte[7:1] != SLAVE_ADDR
        |-> !o_rx_ack)
        else $error("foreign address acknowledged");
    AST_CMD_ACK: assert property (
        want_q && i_rx_valid && !i_start && !i_stop |-> o_rx_ack == known)
        else $error("command acknowledge wrong");
    AST_ACK_QUIET: assert property (!i_rx_valid |-> !o_rx_ack)
        else $error("acknowledge without byte");
    AST_TX_AFTER_REQ: assert property (
        o_tx_valid |-> $past(i_tx_req) && o_busy)
        else $error("reply byte without request");
    AST_TX_HOLD: assert property (!o_tx_valid |-> $stable(o_tx_byte))
        else $error("reply byte changed without valid");
    AST_PEC_LAST: assert property (o_tx_valid |-> ntx_q != 2'h3)
        else $error("reply byte after error code");
    AST_NACK_IDLE: assert property (
        i_tx_nack && !i_start |=> !o_busy)
        else $error("still busy after not-acknowledge");
    AST_STOP_IDLE: assert property (
        i_stop |=> !o_busy ##1 ($past(i_start) || !o_busy))
        else $error("still busy after stop");

    cover property (o_tx_valid && ntx_q == 2'h2);
    cover property ($rose(o_busy));
    cover property (want_q && i_rx_valid && !o_rx_ack);
endmodule

/* File: host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Bus host at byte level
module host_model (
    input  wire logic       i_mclk,
    input  wire logic       i_rx_ack,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_start,
    output logic            o_stop,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_byte,
    output logic            o_tx_req,
    output logic            o_tx_nack
);
    initial begin
        {o_start, o_stop, o_rx_valid, o_tx_req, o_tx_nack} = 5'h0;
        o_rx_byte = 8'hA5;
    end
    task automatic strobe(input int k);
        @(negedge i_mclk);
        {o_tx_nack, o_stop, o_start} = 3'h1 << k;
        @(negedge i_mclk);
        {o_tx_nack, o_stop, o_start} = 3'h0;
    endtask
    task automatic put(input logic [7:0] b, output logic a);
        @(negedge i_mclk);
        o_rx_valid = 1'b1;
        o_rx_byte = b;
        #1 a = i_rx_ack;
        @(negedge i_mclk);
        o_rx_valid = 1'b0;
        o_rx_byte = ~b;
    endtask
    task automatic get(output logic [7:0] b, output logic v);
        @(negedge i_mclk);
        o_tx_req = 1'b1;
        @(negedge i_mclk);
        o_tx_req = 1'b0;
        v = i_tx_valid;
        b = i_tx_byte;
    endtask
    // Write address, command, repeated start, read address, reads
    task automatic read(input logic [7:0] aw, c, input int n, gap,
                        output logic [7:0] d [4], output logic [6:0] ok);
        ok = 7'h0;
        strobe(0);
        put(aw, ok[0]);
        put(c, ok[1]);
        repeat (gap) @(negedge i_mclk);
        strobe(0);
        put(aw | 8'h01, ok[2]);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(negedge i_mclk);
            get(d[i], ok[3 + i]);
        end
        strobe(2);
        strobe(1);
    endtask
endmodule

/* File: protection_limit_readback_tb_top.sv */
`timescale 1ns/1ps

// ==========================================================
// Bench top
module protection_limit_readback_tb_top;
    logic        mclk, rstn, start, stop, rx_valid, tx_req, tx_nack;
    logic [7:0]  rx_byte, tx_byte;
    logic        rx_ack, tx_valid, busy;
    logic [15:0] lim [4];
    logic [3:0]  en;
    logic [2:0]  rs;
    int          mismatches, n_tests;
    localparam logic [7:0] CMDS [7] = '{
        limit_readback_pkg::CMD_OVER_VOLTAGE_PROTECTION_LIMIT,
        limit_readback_pkg::CMD_OVER_VOLTAGE_PROTECTION_RESPONSE,
        limit_readback_pkg::CMD_UNDER_VOLTAGE_PROTECTION_LIMIT,
        limit_readback_pkg::CMD_UNDER_VOLTAGE_PROTECTION_RESPONSE,
        limit_readback_pkg::CMD_OTP_LIMIT,
        limit_readback_pkg::CMD_OTP_RESPONSE,
        limit_readback_pkg::CMD_OVER_POWER_PROTECTION_LIMIT};

    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    protection_limit_readback protection_limit_readback_i (
        .i_mclk(mclk), .i_rstn(rstn), .i_start(start), .i_stop(stop),
        .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_tx_req(tx_req),
        .i_tx_nack(tx_nack),
        .i_over_voltage_protection_limit(lim[0]),
        .i_over_voltage_protection_enable(en[0]),
        .i_over_voltage_protection_restart(rs[0]),
        .i_under_voltage_protection_limit(lim[1]),
        .i_under_voltage_protection_enable(en[1]),
        .i_under_voltage_protection_restart(rs[1]),
        .i_otp_limit(lim[2]), .i_otp_enable(en[2]), .i_otp_restart(rs[2]),
        .i_over_power_protection_limit(lim[3]),
        .i_over_power_protection_enable(en[3]),
        .o_rx_ack(rx_ack), .o_tx_byte(tx_byte), .o_tx_valid(tx_valid),
        .o_busy(busy));
    host_model host_model_i (
        .i_mclk(mclk), .i_rx_ack(rx_ack), .i_tx_valid(tx_valid),
        .i_tx_byte(tx_byte), .o_start(start), .o_stop(stop),
        .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_tx_req(tx_req),
        .o_tx_nack(tx_nack));

    function automatic logic [7:0] crc8(input logic [7:0] c, b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = {r[6:0], 1'b0} ^ (r[7] ? limit_readback_pkg::CRC_POLY : 8'h00);
        end
        return r;
    endfunction
    task automatic check(input string what, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One read, n data bytes expected, two reads beyond them
    task automatic xact(input logic [7:0] aw, c, input int n,
                        input logic [2:0] ea, input logic [15:0] v);
        logic [7:0] d [4];
        logic [6:0] ok;
        logic [7:0] p;
        p = crc8(crc8(crc8(8'h00, aw), c), aw | 8'h01);
        host_model_i.read(aw, c, n + 2, $urandom_range(2), d, ok);
        check("acks", {1'b0, n > 1, n > 0, n > 0, ea}, ok);
        for (int j = 0; j < n; j++) begin
            check("data", v[8 * j +: 8], d[j]);
            p = crc8(p, v[8 * j +: 8]);
        end
        if (n > 0) check("pec", p, d[n]);
    endtask

    initial begin
        int k;
        mismatches = 0;
        n_tests = 0;
        rstn = 1'b0;
        lim = '{16'h0118, 16'h0000, 16'h0000, 16'h0000};
        en = 4'hF;
        rs = 3'h0;
        void'($urandom(32'h44C460DE));
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        xact(8'h20, CMDS[0], 2, 3'h7, 16'h0118);
        for (int r = 0; r < 6; r++) begin
            for (int i = 0; i < 7; i++) begin
                foreach (lim[j]) lim[j] = 16'($urandom);
                en = (r == 0) ? 4'h0 : 4'($urandom);
                rs = 3'($urandom);
                k = i / 2;
                if (i % 2) xact(8'h20, CMDS[i], 1, 3'h7,
                    {8'h00, rs[k] ? 2'h3 : 2'h2, 6'h00});
                else xact(8'h20, CMDS[i], 2, 3'h7,
                    en[k] ? lim[k] : limit_readback_pkg::DISABLED_VALUE);
            end
        end
        xact(8'h20, 8'h42, 0, 3'h1, 16'h0000);
        xact(8'h22, CMDS[0], 0, 3'h0, 16'h0000);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_of_test();
    end
endmodule

bind protection_limit_readback protection_limit_readback_sva #(
    .SLAVE_ADDR(SLAVE_ADDR)
) protection_limit_readback_sva_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(i_start), .i_stop(i_stop),
    .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_tx_req(i_tx_req),
    .i_tx_nack(i_tx_nack), .o_rx_ack(o_rx_ack), .o_tx_byte(o_tx_byte),
    .o_tx_valid(o_tx_valid), .o_busy(o_busy));
